// file: include/mpd_pkg.sv
// Package for the message priority display controller.
// Assumes a single 125 MHz clock and an AHB-Lite register slave.
package mpd_pkg;
    // ------------------------------------------------------------
    // Sizes and timing
    // ------------------------------------------------------------
    localparam int        MSG_MAX        = 50;
    localparam int        IDX_W          = 6;
    localparam int        PRIO_W         = 7;
    localparam int        CLK_MHZ        = 125;
    localparam int        US_PER_MS      = 1000;
    localparam int        HALF_LINE_MULT = 10;
    localparam int        LINE_CHARS     = 24;
    localparam int        POS_W          = 5;
    localparam logic [5:0] NO_MSG        = 6'h3F;
    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_SCROLL   = 8'h04;
    localparam logic [7:0] OFF_ANALOG   = 8'h08;
    localparam logic [7:0] OFF_SEL      = 8'h0C;
    localparam logic [7:0] OFF_CFG      = 8'h10;
    localparam logic [7:0] OFF_STATUS   = 8'h14;
    localparam logic [7:0] OFF_STAMP    = 8'h18;
    localparam logic [7:0] OFF_DSTAMP   = 8'h20;
    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int         CTRL_RUN_BIT      = 0;
    localparam int         CTRL_CSUSE_BIT    = 1;
    localparam int         CTRL_CSSEL_BIT    = 2;
    localparam int         CTRL_HALF_BIT     = 3;
    localparam logic [31:0] SCROLL_RST       = 32'h0000_0064;
    localparam logic [31:0] ANALOG_RST       = 32'h0000_01F4;
    // ------------------------------------------------------------
    // Per-message configuration and displayed-message output
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DST_ONBOARD = 2'b00,
        DST_REMOTE  = 2'b01,
        DST_BOTH    = 2'b10
    } mpd_dest_e;
    typedef struct packed {
        logic [6:0] prio;
        logic       ackHold;
        logic [1:0] dest;
        logic       secondary;
        logic [2:0] lineScroll;
    } mpd_cfg_s;
    typedef struct packed {
        logic       valid;
        logic [5:0] index;
        logic       onboard;
        logic       remote;
        logic [4:0] scrollPos;
        logic       halfRight;
        logic       analogStrobe;
    } mpd_disp_s;
endpackage : mpd_pkg

// file: rtl/mpd_message_display.sv
// Message priority display controller: fifty message instances.
// Assumes enables, keys and time stamps synchronous to clk.
//
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
module mpd_message_display #(
    parameter int MSG_COUNT = mpd_pkg::MSG_MAX,
    parameter int US_PER_MS = mpd_pkg::US_PER_MS
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    // AHB-Lite slave
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic      [31:0]            hrdata,
    output logic                        hreadyout,
    output logic                        hresp,
    // Message instances
    input  wire logic [MSG_COUNT-1:0]   msgEnable,
    output logic      [MSG_COUNT-1:0]   msgActive,
    // Keypad pulses
    input  wire logic                   keyConfirm,
    input  wire logic                   keyUp,
    input  wire logic                   keyDown,
    // Clock of day
    input  wire logic [31:0]            timeOfDay,
    input  wire logic [31:0]            dateNow,
    // Panels
    output mpd_pkg::mpd_disp_s          dispOut,
    output logic      [31:0]            shownTime,
    output logic      [31:0]            shownDate
);
    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic [31:0]        ctrl_reg;
    logic [31:0]        scroll_reg;
    logic [31:0]        analog_reg;
    logic [5:0]         sel_reg;
    mpd_pkg::mpd_cfg_s  cfg_reg [MSG_COUNT];
    logic [31:0]        stampTime_reg [MSG_COUNT];
    logic [31:0]        stampDate_reg [MSG_COUNT];
    logic               wrPend_reg;
    logic [7:0]         wrAddr_reg;
    logic [7:0]         rdAddr;
    logic [5:0]         selIdx;
    logic               runMode;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign runMode   = ctrl_reg[mpd_pkg::CTRL_RUN_BIT];
    assign rdAddr    = haddr[7:0];
    assign selIdx    = (sel_reg < 6'(MSG_COUNT)) ? sel_reg : 6'h00;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wrPend_reg <= 1'b0;
            wrAddr_reg <= 8'h00;
        end
        else if (hready)
        begin
            wrPend_reg <= hsel && htrans[1] && hwrite;
            wrAddr_reg <= haddr[7:0];
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_reg   <= 32'h0000_0000;
            scroll_reg <= mpd_pkg::SCROLL_RST;
            analog_reg <= mpd_pkg::ANALOG_RST;
            sel_reg    <= 6'h00;
        end
        else if (wrPend_reg)
        begin
            case (wrAddr_reg)
                mpd_pkg::OFF_CTRL:   ctrl_reg   <= {28'h000_0000, hwdata[3:0]};
                mpd_pkg::OFF_SCROLL: scroll_reg <= hwdata;
                mpd_pkg::OFF_ANALOG: analog_reg <= hwdata;
                mpd_pkg::OFF_SEL:    sel_reg    <= hwdata[5:0];
                default:             ;
            endcase
        end
    end

    genvar g;
    generate
        for (g = 0; g < MSG_COUNT; g++)
        begin : gCfg
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                    cfg_reg[g] <= '0;
                else if (wrPend_reg && wrAddr_reg == mpd_pkg::OFF_CFG
                         && selIdx == 6'(g))
                    cfg_reg[g] <= hwdata[13:0];
            end
        end
    endgenerate

    // Read data is registered at the address phase.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            hrdata <= 32'h0000_0000;
        else if (hready && hsel && htrans[1] && !hwrite)
        begin
            case (rdAddr)
                mpd_pkg::OFF_CTRL:   hrdata <= ctrl_reg;
                mpd_pkg::OFF_SCROLL: hrdata <= scroll_reg;
                mpd_pkg::OFF_ANALOG: hrdata <= analog_reg;
                mpd_pkg::OFF_SEL:    hrdata <= {26'h000_0000, sel_reg};
                mpd_pkg::OFF_CFG:    hrdata <= {18'h0_0000, cfg_reg[selIdx]};
                mpd_pkg::OFF_STATUS: hrdata <= {24'h00_0000, dispOut.valid,
                                                1'b0, dispOut.index};
                mpd_pkg::OFF_STAMP:  hrdata <= stampTime_reg[selIdx];
                mpd_pkg::OFF_DSTAMP: hrdata <= stampDate_reg[selIdx];
                default:             hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Message instances
    // ------------------------------------------------------------
    logic [MSG_COUNT-1:0] enPrev_reg;
    logic [MSG_COUNT-1:0] risePrev_reg;
    logic [MSG_COUNT-1:0] eligible;
    logic [MSG_COUNT-1:0] rise;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            enPrev_reg   <= '0;
            risePrev_reg <= '0;
        end
        else
        begin
            enPrev_reg   <= msgEnable;
            risePrev_reg <= rise;
        end
    end

    generate
        for (g = 0; g < MSG_COUNT; g++)
        begin : gMsg
            assign rise[g] = msgEnable[g] && !enPrev_reg[g] && runMode;
            assign eligible[g] = msgActive[g] && (!ctrl_reg[mpd_pkg::CTRL_CSUSE_BIT]
                || cfg_reg[g].secondary == ctrl_reg[mpd_pkg::CTRL_CSSEL_BIT]);
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                    msgActive[g] <= 1'b0;
                else if (rise[g])
                    msgActive[g] <= 1'b1;
                else if (!msgEnable[g] && !cfg_reg[g].ackHold)
                    msgActive[g] <= 1'b0;
                else if (!msgEnable[g] && keyConfirm
                         && dispOut.valid && dispOut.index == 6'(g))
                    msgActive[g] <= 1'b0;
            end
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    stampTime_reg[g] <= 32'h0000_0000;
                    stampDate_reg[g] <= 32'h0000_0000;
                end
                else if (rise[g])
                begin
                    stampTime_reg[g] <= timeOfDay;
                    stampDate_reg[g] <= dateNow;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Priority selection
    // ------------------------------------------------------------
    logic [5:0] best;
    logic [6:0] bestPrio;
    logic       bestValid;
    logic [5:0] nextUp;
    logic [5:0] nextDown;
    logic       curOk;

    always_comb
    begin
        best      = mpd_pkg::NO_MSG;
        bestPrio  = 7'h00;
        bestValid = 1'b0;
        for (int i = 0; i < MSG_COUNT; i++)
        begin
            if (eligible[i] && (!bestValid || cfg_reg[i].prio > bestPrio))
            begin
                best      = 6'(i);
                bestPrio  = cfg_reg[i].prio;
                bestValid = 1'b1;
            end
        end
    end

    always_comb
    begin
        nextUp   = dispOut.index;
        nextDown = dispOut.index;
        for (int i = MSG_COUNT - 1; i >= 0; i--)
        begin
            if (eligible[i] && 6'(i) > dispOut.index)
                nextUp = 6'(i);
        end
        for (int i = 0; i < MSG_COUNT; i++)
        begin
            if (eligible[i] && 6'(i) < dispOut.index)
                nextDown = 6'(i);
        end
    end

    assign curOk = dispOut.valid && eligible[dispOut.index];

    // ------------------------------------------------------------
    // Scroll and analog timers
    // ------------------------------------------------------------
    logic [6:0]  usDiv_reg;
    logic [9:0]  msDiv_reg;
    logic        msTick;
    logic [31:0] scrollCnt_reg;
    logic [3:0]  halfCnt_reg;
    logic [31:0] analogCnt_reg;
    logic        scrollTick;

    assign msTick = (msDiv_reg == 10'(US_PER_MS - 1))
                    && (usDiv_reg == 7'(mpd_pkg::CLK_MHZ - 1));

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            usDiv_reg <= 7'h00;
            msDiv_reg <= 10'h000;
        end
        else if (usDiv_reg == 7'(mpd_pkg::CLK_MHZ - 1))
        begin
            usDiv_reg <= 7'h00;
            msDiv_reg <= (msDiv_reg == 10'(US_PER_MS - 1)) ? 10'h000 : msDiv_reg + 10'd1;
        end
        else
            usDiv_reg <= usDiv_reg + 7'd1;
    end

    assign scrollTick = msTick && (scrollCnt_reg + 32'd1 >= scroll_reg);

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            scrollCnt_reg <= 32'h0000_0000;
            analogCnt_reg <= 32'h0000_0000;
        end
        else if (msTick)
        begin
            scrollCnt_reg <= scrollTick ? 32'h0000_0000 : scrollCnt_reg + 32'd1;
            analogCnt_reg <= (analogCnt_reg + 32'd1 >= analog_reg)
                             ? 32'h0000_0000 : analogCnt_reg + 32'd1;
        end
    end

    // ------------------------------------------------------------
    // Displayed message
    // ------------------------------------------------------------
    logic        newDisp;
    logic [5:0]  dispIdx_next;

    always_comb
    begin
        newDisp = 1'b0;
        dispIdx_next = dispOut.index;
        if (!runMode || !bestValid)
            dispIdx_next = mpd_pkg::NO_MSG;
        else if (!curOk)
        begin
            dispIdx_next = best;
            newDisp = 1'b1;
        end
        else if (keyUp && nextUp != dispOut.index)
        begin
            dispIdx_next = nextUp;
            newDisp = 1'b1;
        end
        else if (keyDown && nextDown != dispOut.index)
        begin
            dispIdx_next = nextDown;
            newDisp = 1'b1;
        end
        else if (risePrev_reg[best] && bestPrio > cfg_reg[dispOut.index].prio)
        begin
            dispIdx_next = best;
            newDisp = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dispOut     <= '0;
            halfCnt_reg <= 4'h0;
        end
        else
        begin
            dispOut.index <= dispIdx_next;
            dispOut.valid <= (dispIdx_next != mpd_pkg::NO_MSG);
            dispOut.onboard <= (dispIdx_next != mpd_pkg::NO_MSG)
                && cfg_reg[dispIdx_next % 6'(MSG_COUNT)].dest
                   != mpd_pkg::DST_REMOTE;
            dispOut.remote <= (dispIdx_next != mpd_pkg::NO_MSG)
                && cfg_reg[dispIdx_next % 6'(MSG_COUNT)].dest
                   != mpd_pkg::DST_ONBOARD;
            dispOut.analogStrobe <= msTick && (analogCnt_reg + 32'd1 >= analog_reg);
            if (newDisp)
            begin
                dispOut.scrollPos <= 5'h00;
                dispOut.halfRight <= 1'b0;
                halfCnt_reg       <= 4'h0;
            end
            else if (scrollTick && ctrl_reg[mpd_pkg::CTRL_HALF_BIT])
            begin
                halfCnt_reg <= (halfCnt_reg == 4'(mpd_pkg::HALF_LINE_MULT - 1))
                               ? 4'h0 : halfCnt_reg + 4'd1;
                if (halfCnt_reg == 4'(mpd_pkg::HALF_LINE_MULT - 1))
                    dispOut.halfRight <= !dispOut.halfRight;
            end
            else if (scrollTick)
                dispOut.scrollPos <= (dispOut.scrollPos == 5'(mpd_pkg::LINE_CHARS - 1))
                                     ? 5'h00 : dispOut.scrollPos + 5'd1;
        end
    end

    // Embedded clock fields follow the live clock every cycle.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            shownTime <= 32'h0000_0000;
            shownDate <= 32'h0000_0000;
        end
        else
        begin
            shownTime <= timeOfDay;
            shownDate <= dateNow;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_ack_hold;
        @(posedge clk) disable iff (!reset_n)
        keyConfirm |=> ($past(msgActive & msgEnable) & ~msgActive) == '0;
    endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("ack taken while enabled");

    property p_no_start_level;
        @(posedge clk) disable iff (!reset_n)
        1'b1 |=> (msgActive & ~$past(msgActive) & ~$past(msgEnable & ~enPrev_reg)) == '0;
    endproperty
    a_no_start_level: assert property (p_no_start_level) else $error("level started msg");

    property p_drop_noack;
        @(posedge clk) disable iff (!reset_n)
        (!msgEnable[MSG_COUNT-1] && !cfg_reg[MSG_COUNT-1].ackHold) |=> !msgActive[MSG_COUNT-1];
    endproperty
    a_drop_noack: assert property (p_drop_noack) else $error("msg not dropped");

    property p_run_only;
        @(posedge clk) disable iff (!reset_n)
        !runMode |=> !dispOut.valid;
    endproperty
    a_run_only: assert property (p_run_only) else $error("shown outside run");

    property p_time_follow;
        @(posedge clk) disable iff (!reset_n)
        1'b1 |=> shownTime == $past(timeOfDay);
    endproperty
    a_time_follow: assert property (p_time_follow) else $error("time stale");

    property p_stamp;
        @(posedge clk) disable iff (!reset_n)
        rise[MSG_COUNT-1] |=> stampTime_reg[MSG_COUNT-1] == $past(timeOfDay)
            && stampDate_reg[MSG_COUNT-1] == $past(dateNow);
    endproperty
    a_stamp: assert property (p_stamp) else $error("stamp not latched");

    property p_valid_active;
        @(posedge clk) disable iff (!reset_n)
        (runMode && dispOut.valid && !curOk) |=> (dispOut.index == $past(best));
    endproperty
    a_valid_active: assert property (p_valid_active) else $error("no fallback");

    property p_count;
        @(posedge clk) disable iff (!reset_n)
        dispOut.valid |-> dispOut.index < 6'(MSG_COUNT);
    endproperty
    a_count: assert property (p_count) else $error("index out of range");
endmodule : mpd_message_display

// file: testbench/mpd_message_display_tb.sv
// Self-checking testbench for the message priority display controller.
// Assumes the AHB-Lite slave answers with hreadyout and the keypad model.
`timescale 1ns/1ps
module mpd_message_display_tb;
    logic               clk;
    logic               reset_n;
    logic               hsel;
    logic [31:0]        haddr;
    logic [1:0]         htrans;
    logic               hwrite;
    logic [2:0]         hsize;
    logic [31:0]        hwdata;
    logic [31:0]        hrdata;
    logic               hreadyout;
    logic               hresp;
    logic [49:0]        msgEnable;
    logic [49:0]        msgActive;
    logic               keyConfirm;
    logic               keyUp;
    logic               keyDown;
    logic [31:0]        timeOfDay;
    logic [31:0]        dateNow;
    mpd_pkg::mpd_disp_s dispOut;
    logic [31:0]        shownTime;
    logic [31:0]        shownDate;
    logic [31:0]        rd;
    logic [4:0]         pos0;
    int                 strobe0;
    int                 n_errors;
    int                 cmp_count;

    mpd_message_display #(.MSG_COUNT(50), .US_PER_MS(2)) i_dut (
        .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .msgEnable(msgEnable), .msgActive(msgActive), .keyConfirm(keyConfirm),
        .keyUp(keyUp), .keyDown(keyDown), .timeOfDay(timeOfDay), .dateNow(dateNow),
        .dispOut(dispOut), .shownTime(shownTime), .shownDate(shownDate)
    );
    mpd_panel_model i_panel (
        .clk(clk), .dispOut(dispOut), .keyConfirm(keyConfirm), .keyUp(keyUp),
        .keyDown(keyDown)
    );
    // ------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        close_out();
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= w;
        hsize  <= 3'b010;
        n = 0;
        do @(posedge clk); while (hreadyout !== 1'b1 && ++n < 50);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        n = 0;
        do @(posedge clk); while (hreadyout !== 1'b1 && ++n < 50);
        rd = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string msg);
        bus(1'b0, a, 32'h00000000);
        chk(rd, exp, msg);
    endtask : rdc
    task automatic settle();
        repeat (4) @(posedge clk);
    endtask : settle
    task automatic en(input int i, input logic v);
        msgEnable[i] <= v;
        settle();
    endtask : en
    task automatic act(input int i, input logic v);
        chk({31'h0, msgActive[i]}, {31'h0, v}, "instance output");
    endtask : act
    task automatic dsp(input int i);
        chk({26'h0, dispOut.index}, i, "displayed index");
    endtask : dsp
    task automatic key(input int k);
        i_panel.press(k);
        settle();
    endtask : key
    task automatic cfg(input int i, input logic [31:0] v);
        wr(mpd_pkg::OFF_SEL, i);
        wr(mpd_pkg::OFF_CFG, v);
    endtask : cfg
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        n_errors = 0;
        cmp_count = 0;
        reset_n = 1'b0;
        {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        msgEnable = '0;
        timeOfDay = 32'h00000000;
        dateNow = 32'h00000000;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rdc(mpd_pkg::OFF_SCROLL, mpd_pkg::SCROLL_RST, "scroll reset");
        rdc(mpd_pkg::OFF_ANALOG, mpd_pkg::ANALOG_RST, "analog reset");
        rdc(8'h1C, 32'h00000000, "unmapped read");
        chk({31'h0, hresp}, 32'h00000000, "response");
        wr(mpd_pkg::OFF_ANALOG, 32'h000000FA);
        rdc(mpd_pkg::OFF_ANALOG, 32'h000000FA, "analog interval");
        cfg(3, 32'h00000500);
        cfg(5, 32'h00000A60);
        cfg(49, 32'h00000A10);
        cfg(9, 32'h00003208);
        en(3, 1'b1);
        act(3, 1'b0);
        wr(mpd_pkg::OFF_CTRL, 32'h00000001);
        settle();
        act(3, 1'b0);
        en(3, 1'b0);
        timeOfDay <= 32'h00123456;
        dateNow <= 32'h00020304;
        en(3, 1'b1);
        act(3, 1'b1);
        dsp(3);
        chk({30'h0, dispOut.onboard, dispOut.remote}, 32'h2, "onboard only");
        timeOfDay <= 32'h00123500;
        en(5, 1'b1);
        dsp(5);
        chk({30'h0, dispOut.onboard, dispOut.remote}, 32'h3, "both panels");
        en(49, 1'b1);
        dsp(5);
        act(49, 1'b1);
        key(0);
        act(5, 1'b1);
        en(5, 1'b0);
        act(5, 1'b1);
        dsp(5);
        key(0);
        act(5, 1'b0);
        dsp(49);
        en(49, 1'b0);
        act(49, 1'b0);
        dsp(3);
        en(49, 1'b1);
        dsp(49);
        chk({31'h0, dispOut.remote}, 32'h1, "remote only");
        key(2);
        dsp(3);
        key(1);
        dsp(49);
        wr(mpd_pkg::OFF_CTRL, 32'h00000003);
        en(9, 1'b1);
        chk({31'h0, dispOut.index === 6'd9}, 32'h0, "secondary hidden");
        wr(mpd_pkg::OFF_CTRL, 32'h00000007);
        settle();
        dsp(9);
        wr(mpd_pkg::OFF_SEL, 32'h00000003);
        rdc(mpd_pkg::OFF_STAMP, 32'h00123456, "activation stamp");
        chk(shownTime, 32'h00123500, "shown time");
        chk(shownDate, 32'h00020304, "shown date");
        rdc(mpd_pkg::OFF_DSTAMP, 32'h00020304, "activation date");
        wr(mpd_pkg::OFF_SCROLL, 32'h00000001);
        wr(mpd_pkg::OFF_ANALOG, 32'h00000002);
        repeat (1000) @(posedge clk);
        pos0 = dispOut.scrollPos;
        strobe0 = i_panel.strobeCount;
        repeat (250) @(posedge clk);
        chk(dispOut.scrollPos, (pos0 + 1) % mpd_pkg::LINE_CHARS, "char scroll");
        repeat (750) @(posedge clk);
        chk(i_panel.strobeCount - strobe0, 2, "analog refresh");
        repeat (5000) @(posedge clk);
        chk(dispOut.scrollPos, pos0, "char wrap");
        wr(mpd_pkg::OFF_CTRL, 32'h0000000F);
        repeat (2000) @(posedge clk);
        chk({31'h0, dispOut.halfRight}, 32'h0, "half hold");
        repeat (1000) @(posedge clk);
        chk({31'h0, dispOut.halfRight}, 32'h1, "half swap");
        close_out();
    end
endmodule : mpd_message_display_tb

// file: testbench/mpd_panel_model.sv
// Partner model: the keypad and panels at the controller's far side.
// Assumes it shares clk with the controller and is called just after an edge.
`timescale 1ns/1ps
module mpd_panel_model (
    // Clock
    input  wire logic               clk,
    // Panel view
    input  wire mpd_pkg::mpd_disp_s dispOut,
    // Keypad
    output logic                    keyConfirm,
    output logic                    keyUp,
    output logic                    keyDown
);
    int strobeCount;
    // ------------------------------------------------------------
    // Keypad idles with no key pressed
    // ------------------------------------------------------------
    initial
    begin
        keyConfirm  = 1'b0;
        keyUp       = 1'b0;
        keyDown     = 1'b0;
        strobeCount = 0;
    end
    // Counts analog refresh pulses seen by the panels.
    always @(posedge clk)
        if (dispOut.analogStrobe === 1'b1)
            strobeCount <= strobeCount + 1;
    // Issues a one-cycle key pulse: 0 confirm, 1 up, 2 down.
    task automatic press(input int k);
        keyConfirm <= (k == 0);
        keyUp      <= (k == 1);
        keyDown    <= (k == 2);
        @(posedge clk);
        keyConfirm <= 1'b0;
        keyUp      <= 1'b0;
        keyDown    <= 1'b0;
    endtask : press
endmodule : mpd_panel_model
